/* File: pkg/dbg_action_consts.vh */
`ifndef DBG_ACTION_CONSTS_VH
`define DBG_ACTION_CONSTS_VH

// Register word addresses
`define ADDR_STATUS 4'h0
`define ADDR_EXT_CFG 4'h1
`define ADDR_CREG_CFG 4'h2
`define ADDR_SOFT_CFG 4'h3
`define ADDR_MON_START 4'h4
`define ADDR_CTX_PTR 4'h5
`define ADDR_TRAP_CTRL 4'h6
`define ADDR_CPU_PRIO 4'h7
`define ADDR_BKI_PRIO 4'h8
`define ADDR_TRIG_CFG 4'h9
`define ADDR_PERF 4'hA

// Status register field positions
`define ST_DE 0
`define ST_HALT0 1
`define ST_HALT1 2
`define ST_SIH 3
`define ST_CORE_HOLD_OUT_STATE 4
`define ST_PRIOR_HOLD_OUT_STATE 6
`define ST_POSTED_EVENT_BIT 7
`define ST_SRC_LO 8

// Event configuration field positions
`define CFG_ACTION_SELECT_LO 0
`define CFG_BBM 3
`define CFG_BOD 4
`define CFG_CORE_HOLD_OUT_STATE 5
`define CFG_CNT_LO 6

// Action codes
`define ACTION_SELECT_DISABLED 3'h0
`define ACTION_SELECT_NONE 3'h1
`define ACTION_SELECT_HALT 3'h2
`define ACTION_SELECT_TRAP 3'h3

// Counter control codes
`define CNT_KEEP 2'h0
`define CNT_START 2'h1
`define CNT_STOP 2'h2
`define CNT_TOGGLE 2'h3

// Event source codes
`define SRC_EXT 5'h00
`define SRC_CREG 5'h01
`define SRC_SOFT 5'h02
`define SRC_TRIG 5'h10

// Trap entry values and save offsets
`define SAVE_OFF_LINK 32'h0000_0000
`define SAVE_OFF_STATUS 32'h0000_0004
`define SAVE_OFF_SP 32'h0000_0008
`define SAVE_OFF_RA 32'h0000_000C
`define TRAP_IO_PRIV 2'h2
`define TRAP_CDC 7'h00
`define TRAP_ACTIVE_RESET 1'b1

`endif

/* File: src/debug_action_unit.v */
// Notes on behaviour
// - Each enabled event updates source, and either posted or prior and current hold-out fields.
// - Suspend-out action copies hold-out to prior, then loads from event config.
// - Software write to hold-out bit drives suspend-out; prior stays unchanged.
// - Posted breakpoint interrupt leaves hold-out state untouched but updates source.
// - Events pulse the break-out output to the external debug system.
// - Halt cancels trigger instruction too when break-before-make, else younger only.
// - After cancellation the core halts; halt field reads 01, source updated.
// - Halted core ignores interrupts; resumes when halt field written as 10.
// - Software setting halt enters halt mode as an external event.
// - Trap entry saves link, status, stack, return at pointer plus 0,4,8,C.
// - Trap loads return address from PC, stack from interrupt stack when status bit 9 is clear, saves IE/priority.
// - Trap sets PC to monitor start and loads fixed status word fields.
// - Monitor return restores context, clears trap flag; no-op when debug disabled.
// - No breakpoint traps on context save area accesses by traps or interrupts.
// - Debug mode suppresses protection traps in monitor and save-pointer regions.
// - Trap taken only when trap flag is 0; trap sets it; register writes too.
// - Trap active flag is one after reset; software clears it first.
// - Events may raise one of up to four breakpoint interrupts with own priority.
// - Low-priority breakpoint interrupt posts software interrupt and sets posted bit.
// - Debug actions start, stop, or for triggers toggle, task-mode performance counters.
// - Action none still updates status; action disabled has no effect at all.
// - With debug enabled, suspend-in holds the core halted until negated.
// - Oldest instruction first; then external, PC triggers, core reg, debug, address.
// - Halt write changes halt bit only with upper mask bit; upper bit reads 0.
// - Writing 11 sets halt only when debug enable is set.
//
// The register addresses and the Avalon-MM register port were decided locally.
`include "dbg_action_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module debug_action_unit #(
  parameter NUM_BKI = 4
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  output reg [31:0] avsReadData,
  output wire avsWaitRequest,
  input wire dbgOnIn,
  input wire suspendIn,
  input wire extEventIn,
  input wire [7:0] pcTrigIn,
  input wire coreRegEventIn,
  input wire softEventIn,
  input wire [7:0] addrTrigIn,
  input wire eventOlder,
  input wire [31:0] statusWordIn,
  input wire [31:0] prevContextLinkIn,
  input wire [31:0] stackPtrIn,
  input wire [31:0] returnAddrIn,
  input wire [31:0] progCounterIn,
  input wire [31:0] interruptStackPtrIn,
  input wire interruptEnableIn,
  input wire [7:0] currentCpuPriorityIn,
  input wire monitorReturnOp,
  input wire csaAccess,
  input wire [31:0] fetchAddr,
  input wire [31:0] dataAddr,
  input wire perfTaskMode,
  output reg breakOut,
  output wire suspendOut,
  output wire haltMode,
  output wire irqIgnore,
  output reg cancelTrigger,
  output reg cancelYounger,
  output reg trapEntry,
  output reg [31:0] saveAddr0,
  output reg [31:0] saveData0,
  output reg [31:0] saveData4,
  output reg [31:0] saveData8,
  output reg [31:0] saveDataC,
  output reg [31:0] newReturnAddr,
  output reg [31:0] newStackPtr,
  output reg loadStackPtr,
  output reg [31:0] newProgCounter,
  output reg [31:0] newStatusWord,
  output reg [31:0] newContextLink,
  output reg clearIntrEnable,
  output reg monitorReturn,
  output reg [NUM_BKI-1:0] bkiRequest,
  output reg [NUM_BKI-1:0] bkiPosted,
  output reg [7:0] bkiLevel,
  output wire perfRun,
  output wire noFetchProtTrap,
  output wire noDataProtTrap
);

  reg [1:0] susSyncQ;
  reg [1:0] dbgSyncQ;
  reg [1:0] extSyncQ;
  reg extSeenQ;
  reg [7:0] extCfgQ;
  reg [7:0] cregCfgQ;
  reg [7:0] softCfgQ;
  reg [7:0] trigCfgQ;
  reg [31:0] monStartQ;
  reg [31:0] ctxPtrQ;
  reg trapActiveQ;
  reg haltQ;
  reg suspQ;
  reg prevSuspQ;
  reg postedQ;
  reg [4:0] srcQ;
  reg perfRunQ;
  reg [8*NUM_BKI-1:0] bkiPrioQ;
  reg [7:0] cpuPrioQ;

  wire dbgOn = dbgSyncQ[1];
  wire susIn = susSyncQ[1];
  wire extPulse = extSyncQ[1] & ~extSeenQ;
  wire wrStrobe = avsWrite;

  assign avsWaitRequest = 1'b0;
  assign suspendOut = suspQ;
  // Suspend-in forces halt only while debug is enabled
  // suspend-in halt
  assign haltMode = haltQ | (dbgOn & susIn);
  assign irqIgnore = haltMode;
  assign perfRun = perfRunQ;
  assign noFetchProtTrap = dbgOn & (fetchAddr[31:24] == monStartQ[31:24]);
  assign noDataProtTrap = dbgOn & (dataAddr[31:24] == ctxPtrQ[31:24]);

  // Event selection
  reg evValid;
  reg [4:0] evSrc;
  reg [7:0] evCfg;
  reg evIsTrig;
  integer i;
  always @* begin
    evValid = 1'b0;
    evSrc = `SRC_EXT;
    evCfg = extCfgQ;
    evIsTrig = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (addrTrigIn[i]) begin
        evValid = 1'b1;
        evSrc = `SRC_TRIG + i[4:0];
        evCfg = trigCfgQ;
        evIsTrig = 1'b1;
      end
    end
    if (softEventIn) begin
      evValid = 1'b1;
      evSrc = `SRC_SOFT;
      evCfg = softCfgQ;
      evIsTrig = 1'b0;
    end
    if (coreRegEventIn) begin
      evValid = 1'b1;
      evSrc = `SRC_CREG;
      evCfg = cregCfgQ;
      evIsTrig = 1'b0;
    end
    for (i = 7; i >= 0; i = i - 1) begin
      if (pcTrigIn[i]) begin
        evValid = 1'b1;
        evSrc = `SRC_TRIG + i[4:0];
        evCfg = trigCfgQ;
        evIsTrig = 1'b1;
      end
    end
    // Pipeline-correlated events are served first only when older
    if (extPulse & ~(evValid & eventOlder)) begin
      evValid = 1'b1;
      evSrc = `SRC_EXT;
      evCfg = extCfgQ;
      evIsTrig = 1'b0;
    end
  end

  wire [2:0] action_select = evCfg[`CFG_ACTION_SELECT_LO+2:`CFG_ACTION_SELECT_LO];
  wire [1:0] cnt = evCfg[`CFG_CNT_LO+1:`CFG_CNT_LO];
  wire evAct = dbgOn & evValid & (action_select != `ACTION_SELECT_DISABLED);
  wire isBki = action_select[2];
  wire [1:0] bkiIdx = action_select[1:0];
  wire bkiOk = isBki & ({30'h0000_0000, bkiIdx} < NUM_BKI);
  wire [7:0] bkiPrioSel = bkiPrioQ[8*bkiIdx +: 8];
  wire bkiPost = evAct & bkiOk & (bkiPrioSel < currentCpuPriorityIn);
  wire takeTrap = evAct & (action_select == `ACTION_SELECT_TRAP) & ~trapActiveQ & ~csaAccess;
  wire regWrStatus = wrStrobe & (avsAddress == `ADDR_STATUS);
  wire swHaltSet = regWrStatus & avsWriteData[`ST_HALT1] & avsWriteData[`ST_HALT0] & dbgOn;
  wire swHaltClr = regWrStatus & avsWriteData[`ST_HALT1] & ~avsWriteData[`ST_HALT0];

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      susSyncQ <= 2'h0;
      dbgSyncQ <= 2'h0;
      extSyncQ <= 2'h0;
      extSeenQ <= 1'b0;
    end else begin
      susSyncQ <= {susSyncQ[0], suspendIn};
      dbgSyncQ <= {dbgSyncQ[0], dbgOnIn};
      extSyncQ <= {extSyncQ[0], extEventIn};
      extSeenQ <= extSyncQ[1];
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      extCfgQ <= 8'h00;
      cregCfgQ <= 8'h00;
      softCfgQ <= 8'h00;
      trigCfgQ <= 8'h00;
      monStartQ <= 32'h0000_0000;
      ctxPtrQ <= 32'h0000_0000;
      cpuPrioQ <= 8'h00;
      bkiPrioQ <= {8*NUM_BKI{1'b0}};
      trapActiveQ <= `TRAP_ACTIVE_RESET;
      haltQ <= 1'b0;
      suspQ <= 1'b0;
      prevSuspQ <= 1'b0;
      postedQ <= 1'b0;
      srcQ <= 5'h00;
      perfRunQ <= 1'b0;
    end else begin
      if (wrStrobe) begin
        case (avsAddress)
          `ADDR_EXT_CFG: extCfgQ <= avsWriteData[7:0];
          `ADDR_CREG_CFG: cregCfgQ <= avsWriteData[7:0];
          `ADDR_SOFT_CFG: softCfgQ <= avsWriteData[7:0];
          `ADDR_TRIG_CFG: trigCfgQ <= avsWriteData[7:0];
          `ADDR_MON_START: monStartQ <= avsWriteData;
          `ADDR_CTX_PTR: ctxPtrQ <= avsWriteData;
          `ADDR_CPU_PRIO: cpuPrioQ <= avsWriteData[7:0];
          `ADDR_BKI_PRIO: bkiPrioQ <= avsWriteData[8*NUM_BKI-1:0];
          default: ;
        endcase
      end
      if (regWrStatus) begin
        suspQ <= avsWriteData[`ST_CORE_HOLD_OUT_STATE];
        postedQ <= avsWriteData[`ST_POSTED_EVENT_BIT];
      end
      if (wrStrobe & (avsAddress == `ADDR_TRAP_CTRL))
        trapActiveQ <= avsWriteData[0];
      if (swHaltClr)
        haltQ <= 1'b0;
      if (swHaltSet) begin
        haltQ <= 1'b1;
        srcQ <= `SRC_EXT;
      end
      if (monitorReturnOp & dbgOn)
        trapActiveQ <= 1'b0;
      // Hardware events win over a same-cycle software write
      // status update on event
      if (evAct) begin
        srcQ <= evSrc;
        if (bkiPost) begin
          postedQ <= 1'b1;
        end else begin
          prevSuspQ <= suspQ;
          suspQ <= evCfg[`CFG_CORE_HOLD_OUT_STATE];
        end
        if (perfTaskMode) begin
          case (cnt)
            `CNT_START: perfRunQ <= 1'b1;
            `CNT_STOP: perfRunQ <= 1'b0;
            `CNT_TOGGLE: perfRunQ <= evIsTrig ? ~perfRunQ : perfRunQ;
            default: perfRunQ <= perfRunQ;
          endcase
        end
        if (action_select == `ACTION_SELECT_HALT)
          haltQ <= 1'b1;
        if (takeTrap)
          trapActiveQ <= 1'b1;
      end
    end
  end

  // Action pulses towards the pipeline, one cycle each; trap save and load values hold until the next trap
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      breakOut <= 1'b0;
      cancelTrigger <= 1'b0;
      cancelYounger <= 1'b0;
      trapEntry <= 1'b0;
      saveAddr0 <= 32'h0000_0000;
      saveData0 <= 32'h0000_0000;
      saveData4 <= 32'h0000_0000;
      saveData8 <= 32'h0000_0000;
      saveDataC <= 32'h0000_0000;
      newReturnAddr <= 32'h0000_0000;
      newStackPtr <= 32'h0000_0000;
      loadStackPtr <= 1'b0;
      newProgCounter <= 32'h0000_0000;
      newStatusWord <= 32'h0000_0000;
      newContextLink <= 32'h0000_0000;
      clearIntrEnable <= 1'b0;
      monitorReturn <= 1'b0;
      bkiRequest <= {NUM_BKI{1'b0}};
      bkiPosted <= {NUM_BKI{1'b0}};
      bkiLevel <= 8'h00;
    end else begin
      breakOut <= evAct & ~evCfg[`CFG_BOD];
      cancelTrigger <= evAct & (action_select == `ACTION_SELECT_HALT) & evCfg[`CFG_BBM];
      cancelYounger <= evAct & (action_select == `ACTION_SELECT_HALT);
      trapEntry <= takeTrap;
      clearIntrEnable <= takeTrap;
      monitorReturn <= monitorReturnOp & dbgOn;
      bkiRequest <= (evAct & bkiOk & ~bkiPost) ? ({{NUM_BKI-1{1'b0}}, 1'b1} << bkiIdx)
                    : {NUM_BKI{1'b0}};
      bkiPosted <= bkiPost ? ({{NUM_BKI-1{1'b0}}, 1'b1} << bkiIdx) : {NUM_BKI{1'b0}};
      bkiLevel <= bkiPrioSel;
      if (takeTrap) begin
        saveAddr0 <= ctxPtrQ + `SAVE_OFF_LINK;
        saveData0 <= prevContextLinkIn;
        saveData4 <= statusWordIn;
        saveData8 <= stackPtrIn;
        saveDataC <= returnAddrIn;
        newReturnAddr <= progCounterIn;
        newStackPtr <= interruptStackPtrIn;
        loadStackPtr <= ~statusWordIn[9];
        newContextLink <= {prevContextLinkIn[31:24], interruptEnableIn,
                           currentCpuPriorityIn[6:0], prevContextLinkIn[15:0]};
        newProgCounter <= monStartQ;
        // Stack select sits at bit 9, the same bit the stack load reads
        newStatusWord <= {statusWordIn[31:14], 2'h0, `TRAP_IO_PRIV, 1'b1,
                          1'b0, 1'b0, `TRAP_CDC};
      end else begin
        loadStackPtr <= 1'b0;
      end
    end
  end

  always @* begin
    case (avsAddress)
      `ADDR_STATUS: avsReadData = {19'h00000, srcQ, postedQ, prevSuspQ, 1'b0, suspQ,
                                   susIn & dbgOn, 1'b0, haltMode, dbgOn};
      `ADDR_EXT_CFG: avsReadData = {24'h000000, extCfgQ};
      `ADDR_CREG_CFG: avsReadData = {24'h000000, cregCfgQ};
      `ADDR_SOFT_CFG: avsReadData = {24'h000000, softCfgQ};
      `ADDR_TRIG_CFG: avsReadData = {24'h000000, trigCfgQ};
      `ADDR_MON_START: avsReadData = monStartQ;
      `ADDR_CTX_PTR: avsReadData = ctxPtrQ;
      `ADDR_TRAP_CTRL: avsReadData = {31'h00000000, trapActiveQ};
      `ADDR_CPU_PRIO: avsReadData = {24'h000000, cpuPrioQ};
      `ADDR_BKI_PRIO: avsReadData = {{32-8*NUM_BKI{1'b0}}, bkiPrioQ};
      `ADDR_PERF: avsReadData = {31'h00000000, perfRunQ};
      default: avsReadData = 32'h0000_0000;
    endcase
  end

endmodule
`default_nettype wire

/* File: verif/debug_action_unit_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module debug_action_unit_monitor #(
  parameter NUM_BKI = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic avsWaitRequest,
  input wire logic dbgOnIn,
  input wire logic suspendIn,
  input wire logic [31:0] stackPtrIn,
  input wire logic [31:0] returnAddrIn,
  input wire logic [31:0] progCounterIn,
  input wire logic monitorReturnOp,
  input wire logic haltMode,
  input wire logic irqIgnore,
  input wire logic suspendOut,
  input wire logic cancelTrigger,
  input wire logic cancelYounger,
  input wire logic trapEntry,
  input wire logic [31:0] saveData8,
  input wire logic [31:0] saveDataC,
  input wire logic [31:0] newReturnAddr,
  input wire logic clearIntrEnable,
  input wire logic monitorReturn,
  input wire logic [NUM_BKI-1:0] bkiRequest,
  input wire logic [NUM_BKI-1:0] bkiPosted
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  AST_NO_WAIT: assert property (avsWaitRequest == 1'b0)
    else $error("wait request raised");
  AST_CANCEL_HALTS: assert property ((cancelTrigger || cancelYounger) |-> haltMode)
    else $error("cancel without halt");
  AST_HALT_MUTES_IRQ: assert property (haltMode |-> irqIgnore)
    else $error("interrupts not ignored in halt");
  AST_TRAP_ONCE: assert property (trapEntry |=> !trapEntry)
    else $error("second trap while flag set");
  AST_TRAP_RA: assert property (trapEntry |-> newReturnAddr == $past(progCounterIn) && clearIntrEnable)
    else $error("trap return address wrong");
  AST_TRAP_SAVE: assert property (trapEntry |-> saveData8 == $past(stackPtrIn) && saveDataC == $past(returnAddrIn))
    else $error("trap save data wrong");
  // Five cycles cover the two-stage synchroniser; haltMode follows its output without a register
  AST_SUSPIN_HALT: assert property ((suspendIn && dbgOnIn) [*5] |-> haltMode)
    else $error("suspend-in did not halt");
  AST_MON_RETURN: assert property (monitorReturn |-> $past(monitorReturnOp))
    else $error("monitor return without request");
  AST_BKI_SINGLE: assert property ($onehot0({bkiRequest, bkiPosted}))
    else $error("more than one breakpoint interrupt");
  AST_POST_KEEPS_CORE_HOLD_OUT_STATE: assert property (|bkiPosted |-> $stable(suspendOut))
    else $error("suspend-out changed on posted interrupt");
  cover property (trapEntry);
  cover property (|bkiPosted);
  cover property (cancelTrigger);
endmodule
bind debug_action_unit debug_action_unit_monitor #(.NUM_BKI(NUM_BKI)) mon (
  .sys_clk, .rst_b, .avsWaitRequest, .dbgOnIn, .suspendIn, .stackPtrIn, .returnAddrIn,
  .progCounterIn, .monitorReturnOp, .haltMode, .irqIgnore, .suspendOut, .cancelTrigger,
  .cancelYounger, .trapEntry, .saveData8, .saveDataC, .newReturnAddr, .clearIntrEnable,
  .monitorReturn, .bkiRequest, .bkiPosted
);
`default_nettype wire

/* File: verif/far_debug_side.sv */
`timescale 1ns/1ps
`default_nettype none
module far_debug_side (
  input wire logic sys_clk,
  input wire logic breakOut,
  output logic suspendIn,
  output logic extEventIn
);
  int brkSeen = 0;
  initial begin
    suspendIn = 1'b0;
    extEventIn = 1'b0;
  end
  always @(posedge sys_clk) begin
    if (breakOut === 1'b1)
      brkSeen <= brkSeen + 1;
  end
  task automatic set_core_hold_out_state(input logic v);
    @(posedge sys_clk);
    suspendIn <= v;
  endtask
  // break-in held long enough for the synchroniser
  task automatic raise_ext(input int n);
    @(posedge sys_clk);
    extEventIn <= 1'b1;
    repeat (n) @(posedge sys_clk);
    extEventIn <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* File: verif/test_debug_action_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dbg_action_consts.vh"
module test_debug_action_unit;
  logic sys_clk = 1'b0, rst_b = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, dbgOnIn = 1'b1;
  logic coreRegEventIn = 1'b0, softEventIn = 1'b0, monitorReturnOp = 1'b0, csaAccess = 1'b0;
  logic perfTaskMode = 1'b0, interruptEnableIn = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic [7:0] currentCpuPriorityIn = 8'h00;
  logic [31:0] avsWriteData = 32'h0, statusWordIn = 32'h0, prevContextLinkIn = 32'h0;
  logic [31:0] stackPtrIn = 32'h0, returnAddrIn = 32'h0, progCounterIn = 32'h0;
  logic [31:0] interruptStackPtrIn = 32'h0, fetchAddr = 32'h0, dataAddr = 32'h0;
  logic [31:0] rdData, monStart, ctxPtr, avsReadData, saveAddr0, saveData0, saveData4;
  logic [31:0] saveData8, saveDataC, newReturnAddr, newProgCounter;
  logic [3:0] bkiRequest, bkiPosted;
  logic avsWaitRequest, breakOut, suspendOut, haltMode, irqIgnore, cancelTrigger, trapEntry;
  logic loadStackPtr, clearIntrEnable, monitorReturn, perfRun;
  logic cancelYounger, noFetchProtTrap, noDataProtTrap, eventOlder = 1'b0;
  logic [7:0] pcTrigIn = 8'h00, addrTrigIn = 8'h00, bkiLevel;
  logic [31:0] newStackPtr, newStatusWord, newContextLink;
  wire logic suspendIn, extEventIn;
  logic [7:0] cfgs [4] = '{8'h21, 8'h31, 8'h01, 8'h20};
  int err_total = 0, n_checks = 0, mSrc = 0, mPevt = 0, mPrev = 0, mSusp = 0, n;
  integer seed = 93723;

  debug_action_unit dut (
    .sys_clk, .rst_b, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsReadData,
    .avsWaitRequest, .dbgOnIn, .suspendIn, .extEventIn, .pcTrigIn, .coreRegEventIn,
    .softEventIn, .addrTrigIn, .eventOlder, .statusWordIn, .prevContextLinkIn,
    .stackPtrIn, .returnAddrIn, .progCounterIn, .interruptStackPtrIn, .interruptEnableIn,
    .currentCpuPriorityIn, .monitorReturnOp, .csaAccess, .fetchAddr, .dataAddr, .perfTaskMode,
    .breakOut, .suspendOut, .haltMode, .irqIgnore, .cancelTrigger, .cancelYounger,
    .trapEntry, .saveAddr0, .saveData0, .saveData4, .saveData8, .saveDataC, .newReturnAddr,
    .newStackPtr, .loadStackPtr, .newProgCounter, .newStatusWord, .newContextLink,
    .clearIntrEnable, .monitorReturn, .bkiRequest, .bkiPosted, .bkiLevel, .perfRun,
    .noFetchProtTrap, .noDataProtTrap
  );
  far_debug_side far (.sys_clk, .breakOut, .suspendIn, .extEventIn);

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low; one idle cycle follows release
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= !w;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (avsWaitRequest !== 1'b0 && i < 20);
    rdData = avsReadData;
    if (avsWaitRequest !== 1'b0) begin
      err_total++;
      summarize();
    end
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask

  // Bits of k: soft event, core-register event, monitor return, PC trigger 3, address triggers 1-2
  task automatic ev(input logic [4:0] k);
    @(posedge sys_clk);
    {monitorReturnOp, coreRegEventIn, softEventIn} <= k[2:0];
    pcTrigIn <= {4'h0, k[3], 3'h0};
    addrTrigIn <= {5'h00, {2{k[4]}}, 1'b0};
    eventOlder <= $random(seed);
    {statusWordIn, prevContextLinkIn, stackPtrIn} <= {$random(seed), $random(seed), $random(seed)};
    {returnAddrIn, progCounterIn, interruptStackPtrIn} <= {$random(seed), $random(seed), $random(seed)};
    {fetchAddr, dataAddr, interruptEnableIn} <= {$random(seed), $random(seed), $random(seed)};
    @(posedge sys_clk);
    {monitorReturnOp, coreRegEventIn, softEventIn} <= 3'h0;
    pcTrigIn <= 8'h00;
    addrTrigIn <= 8'h00;
    @(negedge sys_clk);
  endtask

  task automatic model(input logic [7:0] cfg, input int src, input logic posted);
    if (cfg[2:0] != 3'h0) begin
      mSrc = src;
      if (posted)
        mPevt = 1;
      else begin
        mPrev = mSusp;
        mSusp = cfg[5];
      end
    end
  endtask

  task automatic chk_st;
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk({rdData[12:6], rdData[4], suspendOut}, {mSrc[4:0], mPevt[0], mPrev[0], mSusp[0], mSusp[0]});
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, `ADDR_TRAP_CTRL, 32'h0);
    chk(rdData[0], 1'b1);
    bus(1'b1, `ADDR_STATUS, 32'h6);
    @(negedge sys_clk);
    chk({haltMode, irqIgnore}, 2'b11);
    bus(1'b1, `ADDR_STATUS, 32'h2);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk({rdData[12:8], rdData[2:1]}, 7'h01);
    bus(1'b1, `ADDR_STATUS, 32'h4);
    @(negedge sys_clk);
    chk(haltMode, 1'b0);
    @(posedge sys_clk);
    dbgOnIn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    bus(1'b1, `ADDR_STATUS, 32'h6);
    @(negedge sys_clk);
    chk(haltMode, 1'b0);
    @(posedge sys_clk);
    dbgOnIn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int b = 0; b < 2; b++) begin
      bus(1'b1, `ADDR_SOFT_CFG, 32'h2 | (b << 3));
      ev(3'h1);
      chk({breakOut, haltMode, cancelTrigger, cancelYounger}, {2'b11, b[0], 1'b1});
      model(8'h02, 2, 1'b0);
      chk_st();
      bus(1'b1, `ADDR_STATUS, 32'h4);
    end
    foreach (cfgs[i]) begin
      bus(1'b1, `ADDR_SOFT_CFG, {24'h0, cfgs[i]});
      ev(3'h1);
      chk(breakOut, cfgs[i][2:0] != 3'h0 && !cfgs[i][4]);
      model(cfgs[i], 2, 1'b0);
      chk_st();
    end
    bus(1'b1, `ADDR_STATUS, 32'h10);
    mSusp = 1;
    chk_st();
    bus(1'b1, `ADDR_CREG_CFG, 32'h21);
    bus(1'b1, `ADDR_SOFT_CFG, 32'h01);
    ev(3'h3);
    model(8'h21, 1, 1'b0);
    chk_st();
    bus(1'b1, `ADDR_EXT_CFG, 32'h01);
    n = far.brkSeen;
    far.raise_ext(6);
    chk(far.brkSeen - n, 1);
    model(8'h01, 0, 1'b0);
    chk_st();
    far.set_core_hold_out_state(1'b1);
    repeat (6) @(posedge sys_clk);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk({haltMode, rdData[3]}, 2'b11);
    far.set_core_hold_out_state(1'b0);
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(haltMode, 1'b0);
    bus(1'b1, `ADDR_SOFT_CFG, 32'h41);
    perfTaskMode <= 1'b1;
    ev(3'h1);
    chk(perfRun, 1'b1);
    bus(1'b1, `ADDR_SOFT_CFG, 32'h81);
    ev(3'h1);
    chk(perfRun, 1'b0);
    model(8'h41, 2, 1'b0);
    model(8'h81, 2, 1'b0);
    bus(1'b1, `ADDR_TRIG_CFG, 32'hC1);
    ev(5'h18);
    model(8'hC1, 8'h13, 1'b0);
    chk(perfRun, 1'b1);
    chk_st();
    ev(5'h10);
    model(8'hC1, 8'h11, 1'b0);
    chk(perfRun, 1'b0);
    chk_st();
    bus(1'b1, `ADDR_BKI_PRIO, 32'h40302010);
    currentCpuPriorityIn <= 8'h25;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `ADDR_SOFT_CFG, 32'h24 + k);
      ev(3'h1);
      chk({bkiPosted, bkiRequest}, k < 2 ? 8'h10 << k : 8'h01 << k);
      chk(bkiLevel, 8'h10 * (k + 1));
      model(8'h24 + k, 2, k < 2);
      chk_st();
    end
    monStart = $random(seed);
    ctxPtr = $random(seed);
    bus(1'b1, `ADDR_MON_START, monStart);
    bus(1'b1, `ADDR_CTX_PTR, ctxPtr);
    bus(1'b1, `ADDR_TRAP_CTRL, 32'h0);
    bus(1'b1, `ADDR_SOFT_CFG, 32'h03);
    csaAccess <= 1'b1;
    ev(3'h1);
    chk(trapEntry, 1'b0);
    @(posedge sys_clk);
    csaAccess <= 1'b0;
    ev(3'h1);
    chk({saveAddr0, saveData0}, {ctxPtr, prevContextLinkIn});
    chk({saveData4, saveData8}, {statusWordIn, stackPtrIn});
    chk({saveDataC, newReturnAddr}, {returnAddrIn, progCounterIn});
    chk({newProgCounter, trapEntry, clearIntrEnable, loadStackPtr}, {monStart, 2'b11, ~statusWordIn[9]});
    chk(newStatusWord, {statusWordIn[31:14], 2'h0, 2'h2, 1'b1, 1'b0, 1'b0, 7'h00});
    chk({newStackPtr, newContextLink[23:16]}, {interruptStackPtrIn, interruptEnableIn, currentCpuPriorityIn[6:0]});
    @(posedge sys_clk);
    fetchAddr <= {monStart[31:24], 24'h123456};
    dataAddr <= {~ctxPtr[31:24], 24'h000000};
    @(negedge sys_clk);
    chk({noFetchProtTrap, noDataProtTrap}, 2'b10);
    @(posedge sys_clk);
    fetchAddr <= {~monStart[31:24], 24'h000000};
    dataAddr <= {ctxPtr[31:24], 24'hABCDEF};
    @(negedge sys_clk);
    chk({noFetchProtTrap, noDataProtTrap}, 2'b01);
    ev(3'h1);
    chk(trapEntry, 1'b0);
    bus(1'b0, `ADDR_TRAP_CTRL, 32'h0);
    chk(rdData[0], 1'b1);
    ev(3'h4);
    chk(monitorReturn, 1'b1);
    bus(1'b0, `ADDR_TRAP_CTRL, 32'h0);
    chk(rdData[0], 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
